// *** hw/qseq_pkg.sv ***
// Constants and types shared by the divide sequencer design files.
package qseq_pkg;
    localparam int WORD_W = 18;
    localparam int REM_W = 20;
    // Leading four octal digits of the opcodes.
    localparam logic [11:0] OP_LONG_U = 12'hd03;
    localparam logic [11:0] OP_LONG_S = 12'hd23;
    localparam logic [11:0] OP_INT_U = 12'hd5b;
    localparam logic [11:0] OP_INT_S = 12'hd7b;
    localparam logic [11:0] OP_FRAC_U = 12'hd43;
    localparam logic [11:0] OP_FRAC_S = 12'hd63;
    localparam int OPC_LSB = 6;
    localparam int SIGNED_BIT = 11;
    localparam int COUNT_W = 6;
    // Register map, byte addresses.
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] IND_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] SEL_QUOT = 2'h0;
    localparam logic [1:0] SEL_COUNT = 2'h1;
    localparam logic [1:0] SEL_CTRL = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Control word positions.
    localparam int IND_SETUP = 6;
    localparam int IND_PRODUCT = 7;
    localparam int IND_DIVIDE = 8;
    localparam int IND_SIGN = 13;
    localparam int IND_NEG = 14;
    localparam int IND_OVF = 15;
    localparam int IND_FULL = 16;
    localparam int IND_NOSHIFT = 17;

    typedef enum logic [7:0] {
        QSEQ_IDLE = 8'h01,
        QSEQ_PA = 8'h02,
        QSEQ_PB = 8'h04,
        QSEQ_PC = 8'h08,
        QSEQ_PD = 8'h10,
        QSEQ_PE = 8'h20,
        QSEQ_PR = 8'h40,
        QSEQ_PF = 8'h80
    } qseq_state_t;
endpackage

// *** hw/qseq_adder.sv ***
// Partial remainder adder that adds or subtracts the divisor.
`timescale 1ns/10ps
module qseq_adder
    import qseq_pkg::*;
(
    input wire logic [REM_W-1:0] rem,
    input wire logic [WORD_W-1:0] operand,
    input wire logic subtract,
    output logic [REM_W-1:0] adder_output
);
    logic [REM_W-1:0] ext;

    // Subtraction is a two's complement add of the zero-extended divisor.
    always_comb
    begin
        ext = {{(REM_W-WORD_W){1'b0}}, operand};
        adder_output = subtract ? rem - ext : rem + ext;
    end
endmodule

// *** hw/qseq_axil.sv ***
// AXI4-Lite slave holding the control register and status views.
`timescale 1ns/10ps
module qseq_axil
    import qseq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [WORD_W-1:0] indicator,
    input wire logic [2:0] status,
    output logic [1:0] sel
);
    logic aw_reg, aw_next, w_reg, w_next, bv_reg, bv_next, rv_reg, rv_next;
    logic [3:0] wa_reg, wa_next;
    logic [1:0] wd_reg, wd_next, sel_reg, sel_next, br_reg, br_next;
    logic [1:0] rr_reg, rr_next;
    logic [31:0] rd_reg, rd_next;

    // Address and data are caught separately, so either may come first.
    always_comb
    begin
        aw_next = aw_reg;
        w_next = w_reg;
        wa_next = wa_reg;
        wd_next = wd_reg;
        bv_next = bv_reg;
        br_next = br_reg;
        sel_next = sel_reg;
        rv_next = rv_reg;
        rr_next = rr_reg;
        rd_next = rd_reg;
        if (awvalid && awready)
        begin
            aw_next = 1'b1;
            wa_next = awaddr;
        end
        if (wvalid && wready)
        begin
            w_next = 1'b1;
            wd_next = wstrb[0] ? wdata[1:0] : sel_reg;
        end
        if (aw_reg && w_reg)
        begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bv_next = 1'b1;
            br_next = RESP_OKAY;
            if (wa_reg == CTRL_OFS)
                sel_next = wd_reg;
            else if (wa_reg != IND_OFS && wa_reg != STATUS_OFS)
                br_next = RESP_SLVERR;
        end
        if (bv_reg && bready)
            bv_next = 1'b0;
        if (arvalid && arready)
        begin
            rv_next = 1'b1;
            rr_next = RESP_OKAY;
            case (araddr)
                CTRL_OFS: rd_next = {30'h0, sel_reg};
                IND_OFS: rd_next = {14'h0, indicator};
                STATUS_OFS: rd_next = {29'h0, status};
                default:
                begin
                    rd_next = 32'h0;
                    rr_next = RESP_SLVERR;
                end
            endcase
        end
        else if (rv_reg && rready)
            rv_next = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            wa_reg <= 4'h0;
            wd_reg <= 2'h0;
            bv_reg <= 1'b0;
            br_reg <= RESP_OKAY;
            sel_reg <= CTRL_RESET;
            rv_reg <= 1'b0;
            rr_reg <= RESP_OKAY;
            rd_reg <= 32'h0;
        end
        else
        begin
            aw_reg <= aw_next;
            w_reg <= w_next;
            wa_reg <= wa_next;
            wd_reg <= wd_next;
            bv_reg <= bv_next;
            br_reg <= br_next;
            sel_reg <= sel_next;
            rv_reg <= rv_next;
            rr_reg <= rr_next;
            rd_reg <= rd_next;
        end
    end

    // Each channel accepts again only once its response has drained.
    assign awready = !aw_reg && !bv_reg;
    assign wready = !w_reg && !bv_reg;
    assign bvalid = bv_reg;
    assign bresp = br_reg;
    assign arready = !rv_reg;
    assign rvalid = rv_reg;
    assign rresp = rr_reg;
    assign rdata = rd_reg;
    assign sel = sel_reg;
endmodule

// *** hw/qseq_top.sv ***
// Divide sequencer: decode, preparation, divide loop and indicators.
`timescale 1ns/10ps
module qseq_top
    import qseq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [WORD_W-1:0] instr,
    input wire logic [WORD_W-1:0] acc_in,
    input wire logic [WORD_W-1:0] mq_in,
    input wire logic link_in,
    output logic mem_rd_req,
    input wire logic mem_rd_valid,
    input wire logic [WORD_W-1:0] mem_rd_data,
    output logic done,
    output logic busy,
    output logic [WORD_W-1:0] accumulator,
    output logic [WORD_W-1:0] multiplier_quotient_reg,
    output logic link_out,
    input wire logic [3:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [3:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    qseq_state_t state_reg, state_next;
    logic [REM_W-1:0] rem_reg, rem_next, adder_output;
    logic [WORD_W-1:0] mq_reg, mq_next, memory_operand_reg, mo_next;
    logic [WORD_W-1:0] instr_reg, instr_next, ind_word, ctrl_word;
    logic [COUNT_W-1:0] step_counter, cnt_next;
    logic step_count_wrap, wrap_next, link_reg, link_next;
    logic sign_reg, sign_next, result_negate_flag, neg_next;
    logic ovf_reg, ovf_next, temp_reg, temp_next, first_reg, first_next;
    logic suppress_shift_state, noshift_next, done_reg, done_next;
    logic is_int, is_frac, is_signed, hit, q_bit;
    logic [11:0] opc;
    logic [1:0] sel;

    // Opcode decode; the step count sits in the low six bits.
    assign opc = instr[WORD_W-1:OPC_LSB];
    assign hit = (opc == OP_LONG_U) || (opc == OP_LONG_S)
        || (opc == OP_INT_U) || (opc == OP_INT_S)
        || (opc == OP_FRAC_U) || (opc == OP_FRAC_S);
    assign is_int = (instr_reg[WORD_W-1:OPC_LSB] == OP_INT_U)
        || (instr_reg[WORD_W-1:OPC_LSB] == OP_INT_S);
    assign is_frac = (instr_reg[WORD_W-1:OPC_LSB] == OP_FRAC_U)
        || (instr_reg[WORD_W-1:OPC_LSB] == OP_FRAC_S);
    assign is_signed = instr_reg[SIGNED_BIT];

    // The last-result bit picks add or subtract; the first step subtracts.
    qseq_adder u_adder (
        .rem(rem_reg),
        .operand(memory_operand_reg),
        .subtract((state_reg == QSEQ_PE) && !temp_reg),
        .adder_output(adder_output)
    );
    assign q_bit = !adder_output[REM_W-1];

    // Sequencer next-state and datapath next values.
    always_comb
    begin
        state_next = state_reg;
        rem_next = rem_reg;
        mq_next = mq_reg;
        mo_next = memory_operand_reg;
        instr_next = instr_reg;
        cnt_next = step_counter;
        wrap_next = step_count_wrap;
        link_next = link_reg;
        sign_next = sign_reg;
        neg_next = result_negate_flag;
        ovf_next = ovf_reg;
        temp_next = temp_reg;
        first_next = first_reg;
        noshift_next = suppress_shift_state;
        done_next = 1'b0;
        mem_rd_req = 1'b0;
        case (state_reg)
            QSEQ_IDLE:
            begin
                // A start that is not a divide is ignored.
                if (start && hit)
                begin
                    instr_next = instr;
                    rem_next = {2'b00, acc_in};
                    mq_next = mq_in;
                    link_next = link_in;
                    sign_next = 1'b0;
                    neg_next = 1'b0;
                    ovf_next = 1'b0;
                    noshift_next = 1'b0;
                    state_next = QSEQ_PA;
                end
            end
            QSEQ_PA:
            begin
                cnt_next = -instr_reg[COUNT_W-1:0];
                wrap_next = 1'b0;
                sign_next = is_signed && rem_reg[WORD_W-1];
                neg_next = is_signed && (link_reg != rem_reg[WORD_W-1]);
                // Integer divide keeps the raw dividend for phase B.
                if (is_signed && rem_reg[WORD_W-1] && !is_int)
                    rem_next = {2'b00, ~rem_reg[WORD_W-1:0]};
                state_next = QSEQ_PB;
            end
            QSEQ_PB:
            begin
                if (is_frac)
                    mq_next = '0;
                else if (is_int)
                    mq_next = sign_reg ? ~rem_reg[WORD_W-1:0]
                        : rem_reg[WORD_W-1:0];
                else if (sign_reg)
                    mq_next = ~mq_reg;
                state_next = QSEQ_PC;
            end
            QSEQ_PC:
            begin
                {wrap_next, cnt_next} = {1'b0, step_counter} + 7'h01;
                if (is_int)
                    rem_next = '0;
                state_next = QSEQ_PD;
            end
            QSEQ_PD:
            begin
                // Divisor comes from the next sequential word.
                mem_rd_req = 1'b1;
                if (mem_rd_valid)
                begin
                    mo_next = mem_rd_data;
                    first_next = 1'b1;
                    temp_next = 1'b0;
                    state_next = QSEQ_PE;
                end
            end
            QSEQ_PE:
            begin
                first_next = 1'b0;
                if (first_reg && q_bit)
                begin
                    // Divisor not above the accumulator half.
                    link_next = 1'b1;
                    ovf_next = 1'b1;
                    done_next = 1'b1;
                    state_next = QSEQ_IDLE;
                end
                else
                begin
                    temp_next = !q_bit;
                    link_next = adder_output[WORD_W-1];
                    mq_next = {mq_reg[WORD_W-2:0], q_bit};
                    if (step_count_wrap)
                    begin
                        rem_next = adder_output;
                        noshift_next = 1'b1;
                        // Only overflow may leave the link set, so the
                        // sign of the last unshifted sum never reaches it.
                        link_next = 1'b0;
                        state_next = q_bit ? QSEQ_PF : QSEQ_PR;
                    end
                    else
                    begin
                        rem_next = {adder_output[REM_W-2:0],
                            mq_reg[WORD_W-1]};
                        {wrap_next, cnt_next} = {1'b0, step_counter}
                            + 7'h01;
                    end
                end
            end
            QSEQ_PR:
            begin
                rem_next = adder_output;
                state_next = QSEQ_PF;
            end
            QSEQ_PF:
            begin
                if (result_negate_flag)
                    mq_next = ~mq_reg;
                if (sign_reg)
                    rem_next = {2'b00, ~rem_reg[WORD_W-1:0]};
                done_next = 1'b1;
                state_next = QSEQ_IDLE;
            end
            default:
                state_next = QSEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_reg <= QSEQ_IDLE;
            rem_reg <= '0;
            mq_reg <= '0;
            memory_operand_reg <= '0;
            instr_reg <= '0;
            step_counter <= '0;
            step_count_wrap <= 1'b0;
            link_reg <= 1'b0;
            sign_reg <= 1'b0;
            result_negate_flag <= 1'b0;
            ovf_reg <= 1'b0;
            temp_reg <= 1'b0;
            first_reg <= 1'b0;
            suppress_shift_state <= 1'b0;
            done_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            rem_reg <= rem_next;
            mq_reg <= mq_next;
            memory_operand_reg <= mo_next;
            instr_reg <= instr_next;
            step_counter <= cnt_next;
            step_count_wrap <= wrap_next;
            link_reg <= link_next;
            sign_reg <= sign_next;
            result_negate_flag <= neg_next;
            ovf_reg <= ovf_next;
            temp_reg <= temp_next;
            first_reg <= first_next;
            suppress_shift_state <= noshift_next;
            done_reg <= done_next;
        end
    end

    // Indicator lamps are active low; idle decodes read as ones.
    always_comb
    begin
        ctrl_word = '1;
        ctrl_word[5:0] = ~{state_reg == QSEQ_PF, state_reg == QSEQ_PE,
            state_reg == QSEQ_PD, state_reg == QSEQ_PC,
            state_reg == QSEQ_PB, state_reg == QSEQ_PA};
        ctrl_word[IND_SETUP] = !(state_reg == QSEQ_PA
            || state_reg == QSEQ_PB || state_reg == QSEQ_PC
            || state_reg == QSEQ_PD);
        ctrl_word[IND_PRODUCT] = 1'b1;
        ctrl_word[IND_DIVIDE] = !busy;
        ctrl_word[IND_SIGN] = !sign_reg;
        ctrl_word[IND_NEG] = !result_negate_flag;
        ctrl_word[IND_OVF] = !ovf_reg;
        ctrl_word[IND_FULL] = !step_count_wrap;
        ctrl_word[IND_NOSHIFT] = !suppress_shift_state;
        case (sel)
            SEL_QUOT: ind_word = mq_reg;
            SEL_COUNT: ind_word = {11'h0, step_count_wrap, step_counter};
            SEL_CTRL: ind_word = ctrl_word;
            default: ind_word = '0;
        endcase
    end

    qseq_axil u_axil (
        .clk(clk),
        .srst(srst),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .indicator(ind_word),
        .status({ovf_reg, link_reg, busy}),
        .sel(sel)
    );

    // Results come straight from the datapath flip-flops.
    assign busy = (state_reg != QSEQ_IDLE);
    assign done = done_reg;
    assign accumulator = rem_reg[WORD_W-1:0];
    assign multiplier_quotient_reg = mq_reg;
    assign link_out = link_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_go_long;
        state_reg == QSEQ_IDLE && start && opc == OP_LONG_S;
    endsequence
    sequence s_go_int;
        state_reg == QSEQ_IDLE && start && opc == OP_INT_U;
    endsequence

    AST_LONG_DECODE:
        assert property (s_go_long |=> state_reg == QSEQ_PA ##1
            state_reg == QSEQ_PB ##1 state_reg == QSEQ_PC)
        else $error("long divide not started");
    AST_INT_PREP:
        assert property (s_go_int |=> ##3 mq_reg == $past(acc_in, 4)
            && rem_reg == '0)
        else $error("integer preparation wrong");
    AST_ABS:
        assert property (state_reg == QSEQ_PA && is_signed && !is_int
            && rem_reg[WORD_W-1] |=> rem_reg[WORD_W-1:0]
            == ~$past(rem_reg[WORD_W-1:0]) && sign_reg)
        else $error("absolute value not formed");
    AST_COUNT_LOAD:
        assert property (state_reg == QSEQ_PA |=> ##2
            step_counter == $past(-instr_reg[COUNT_W-1:0], 3) + 6'h01)
        else $error("step counter load wrong");
    AST_OVERFLOW:
        assert property (state_reg == QSEQ_PE && first_reg && q_bit
            |=> link_out && ovf_reg && done && !busy)
        else $error("overflow not stopped");
    AST_FRAC_CLEAR:
        assert property (state_reg == QSEQ_PB && is_frac |=> mq_reg == '0)
        else $error("fraction quotient not cleared");
    AST_NO_SHIFT:
        assert property (state_reg == QSEQ_PE && step_count_wrap
            && !(first_reg && q_bit) |=> suppress_shift_state
            && rem_reg == $past(adder_output))
        else $error("final step shifted");
    AST_RESTORE:
        assert property (state_reg == QSEQ_PE && step_count_wrap && !q_bit
            && !first_reg |=> state_reg == QSEQ_PR ##1
            state_reg == QSEQ_PF && !rem_reg[REM_W-1])
        else $error("remainder not restored");
    AST_FETCH:
        assert property (state_reg == QSEQ_PD && mem_rd_valid |=>
            memory_operand_reg == $past(mem_rd_data)
            && state_reg == QSEQ_PE)
        else $error("divisor not fetched");
    AST_SIGN_FIX:
        assert property (state_reg == QSEQ_PF && result_negate_flag
            |=> mq_reg == ~$past(mq_reg) && done)
        else $error("quotient sign not fixed");
    AST_LINK_CLEAR:
        assert property (state_reg == QSEQ_PF |=> !link_out && done)
        else $error("link set after a normal divide");
endmodule

// *** testbench/qseq_mem_model.sv ***
// Core memory stand-in that returns the divisor after a set delay.
`timescale 1ns/10ps
module qseq_mem_model
    import qseq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic mem_rd_req,
    input wire logic [WORD_W-1:0] divisor,
    input wire logic [3:0] lat,
    output logic mem_rd_valid,
    output logic [WORD_W-1:0] mem_rd_data
);
    logic [3:0] wait_reg;
    logic [3:0] wait_next;
    // Count the cycles of a pending fetch and clear between fetches.
    always_comb
    begin
        wait_next = (mem_rd_req && !mem_rd_valid) ? wait_reg + 4'h1 : 4'h0;
    end
    always_ff @(posedge clk)
    begin
        wait_reg <= srst ? 4'h0 : wait_next;
    end
    // Off-cycle data is inverted so it never passes for the divisor.
    assign mem_rd_valid = mem_rd_req && (wait_reg == lat);
    assign mem_rd_data = mem_rd_valid ? divisor : ~divisor;
endmodule

// *** testbench/quotient_sequencer_tb.sv ***
// Self-checking bench for the divide sequencer and its register port.
`timescale 1ns/10ps
module quotient_sequencer_tb;
    import qseq_pkg::*;
    logic clk = 0, srst = 1, start = 0, link_in = 0;
    logic [17:0] instr = 0, acc_in = 0, mq_in = 0, divisor = 0;
    logic [3:0] lat = 0, awaddr = 0, araddr = 0, wstrb = 4'hf;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic mem_rd_req, mem_rd_valid, done, busy, link_out;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [17:0] mem_rd_data, accumulator, multiplier_quotient_reg;
    int err_count = 0, comparisons = 0, cyc = 0;
    qseq_top dut (.clk(clk), .srst(srst), .start(start), .instr(instr),
        .acc_in(acc_in), .mq_in(mq_in), .link_in(link_in),
        .mem_rd_req(mem_rd_req), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data), .done(done), .busy(busy),
        .accumulator(accumulator),
        .multiplier_quotient_reg(multiplier_quotient_reg),
        .link_out(link_out), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    qseq_mem_model mem (.clk(clk), .srst(srst), .mem_rd_req(mem_rd_req),
        .divisor(divisor), .lat(lat), .mem_rd_valid(mem_rd_valid),
        .mem_rd_data(mem_rd_data));
    // The clock runs at 25 MHz.
    always #20 clk = ~clk;
    // A hang is cut short well after the longest expected run.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic void chk(input logic [31:0] g, e, input string m);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h", $time, m, g);
        end
    endfunction
    // Runs one divide; done and link are always checked, remainder and quotient only when full is set.
    task automatic run(input logic [17:0] ins, a, q, input logic l,
        input logic [17:0] dv, input logic [3:0] lt,
        input logic [17:0] ea, eq, input logic el, full);
        int n = 0;
        @(posedge clk);
        start <= 1;
        instr <= ins;
        acc_in <= a;
        mq_in <= q;
        link_in <= l;
        divisor <= dv;
        lat <= lt;
        @(posedge clk);
        start <= 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (done !== 1'b1 && n < 200);
        chk(done, 1, "no done");
        chk(link_out, el, "link");
        if (full)
        begin
            chk(accumulator, ea, "remainder");
            chk(multiplier_quotient_reg, eq, "quotient");
        end
        $display("divide test %h finished", ins);
    endtask
    // Write with address and data offered together.
    task automatic axw(input logic [3:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do
        begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1 && n < 50);
        bready <= 0;
        chk(bresp, er, "write response");
    endtask
    task automatic axr(input logic [3:0] a, input logic [31:0] m, e,
        input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do
        begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1 && n < 50);
        rready <= 0;
        chk(rdata & m, e, "read data");
        chk(rresp, er, "read response");
    endtask
    // Main sequence of tests.
    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 0;
        run({12'hd03, 6'h13}, 0, 'h0a, 0, 5, 0, 0, 2, 0, 1);
        axr(4'h4, 32'h3ffff, 2, RESP_OKAY);
        axw(4'h0, 1, RESP_OKAY);
        axr(4'h4, 32'h7f, 32'h40, RESP_OKAY);
        axw(4'h0, 2, RESP_OKAY);
        axr(4'h0, 32'h3, 2, RESP_OKAY);
        axr(4'h4, 32'hffff, 32'hffff, RESP_OKAY);
        run({12'hd03, 6'h13}, 3, 'h1234, 0, 7, 5, 1, 'h1b975, 0, 1);
        run({12'hd23, 6'h13}, 'h3ffff, 'h3fff5, 0, 5, 1,
            'h3ffff, 'h3fffd, 0, 1);
        run({12'hd5b, 6'h13}, 'h64, 'h155, 0, 7, 0, 2, 'he, 0, 1);
        run({12'hd7b, 6'h13}, 'h3ff9b, 0, 0, 7, 2,
            'h3fffd, 'h3fff1, 0, 1);
        run({12'hd43, 6'h13}, 1, 'h2aaaa, 0, 2, 0, 0, 'h20000, 0, 1);
        run({12'hd63, 6'h13}, 1, 'h2aaaa, 0, 4, 3, 0, 'h10000, 0, 1);
        run({12'hd03, 6'h13}, 5, 0, 0, 5, 0, 0, 0, 1, 0);
        axr(4'h4, 32'h8000, 0, RESP_OKAY);
        axr(4'h8, 32'h7, 6, RESP_OKAY);
        axw(4'h4, 1, RESP_OKAY);
        axw(4'hc, 1, RESP_SLVERR);
        axr(4'hc, 32'hffffffff, 0, RESP_SLVERR);
        // A code outside the divide set must leave the unit idle.
        @(posedge clk);
        start <= 1;
        instr <= {12'hd00, 6'h13};
        @(posedge clk);
        start <= 0;
        @(posedge clk);
        #1;
        chk(busy, 0, "busy on other code");
        $display("register tests finished");
        conclude();
    end
endmodule
